// [logic/ffsg_pkg.sv]
// Shared constants and types of the flash flag status and write guard
package ffsg_pkg;

	// Flag status bit positions
	localparam logic [2:0] FS_RDY  = 3'h7;
	localparam logic [2:0] FS_ESUS = 3'h6;
	localparam logic [2:0] FS_EERR = 3'h5;
	localparam logic [2:0] FS_PERR = 3'h4;
	localparam logic [2:0] FS_VERR = 3'h3;
	localparam logic [2:0] FS_PSUS = 3'h2;
	localparam logic [2:0] FS_PROT = 3'h1;
	localparam logic [7:0] FLAG_RST = 8'h80;

	// Instruction codes
	localparam logic [7:0] OP_WRITE_ENABLE    = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE   = 8'h04;
	localparam logic [7:0] OP_WRITE_STATUS    = 8'h01;
	localparam logic [7:0] OP_LOCK_WRITE      = 8'hE5;
	localparam logic [7:0] OP_OTP             = 8'h42;
	localparam logic [7:0] OP_PAGE_PROGRAM    = 8'h02;
	localparam logic [7:0] OP_DFP             = 8'hA2;
	localparam logic [7:0] OP_DEFP            = 8'hD2;
	localparam logic [7:0] OP_QFP             = 8'h32;
	localparam logic [7:0] OP_QEFP            = 8'h12;
	localparam logic [7:0] OP_SUBSECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_LWIPE = 8'hD8;
	localparam logic [7:0] OP_CWIPE = 8'hC7;
	localparam logic [7:0] OP_SUSP  = 8'h75;
	localparam logic [7:0] OP_RESM  = 8'h7A;
	localparam logic [7:0] OP_CLRF  = 8'h50;

	// Timing
	localparam int unsigned CLK_MHZ     = 100;
	localparam int unsigned PUW_TIME_US = 1000;

	typedef enum logic [1:0] {
		P_EXT  = 2'h0,
		P_DUAL = 2'h1,
		P_QUAD = 2'h2
	} ffsg_proto_e;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_PROG  = 4'h2,
		ST_ERASE = 4'h4,
		ST_REG   = 4'h8
	} ffsg_op_e;

	typedef struct packed {
		logic done;
		logic fail;
		logic one_on_zero;
		logic pattern_64;
		logic halted;
	} ffsg_eng_s;

	typedef struct packed {
		logic sector_locked;
		logic otp_locked;
		logic status_write_disable_bit;
	} ffsg_prot_s;

	typedef struct packed {
		logic       start;
		logic [7:0] opcode;
	} ffsg_start_s;

endpackage

// [logic/ffsg_flag_guard.sv]
// Flag status bits and write guard of a serial flash
// Notes on behaviour
// - Suspend during erase sets erase-suspended flag
// - Resume clears erase-suspended flag
// - Suspend during program sets program-suspended flag
// - Resume clears program-suspended flag
// - Erase failure or protection sets erase error
// - Erase error covers all erases, protocols
// - Error bits stick until clear-flags command
// - Pending own-kind, protection or supply error makes new program or erase fail; register writes only on protection
// - Program failure or protection sets program error
// - Zero-to-one error only boosted, 64-bit multiple
// - Program error instruction set depends on protocol
// - Boost lost during program or erase sets supply error
// - Locked sector or OTP sets protection error
// - Refused status write sets protection error
// - Modify accepted only on whole bytes
// - Modify runs only with write latch set
// - Latch cleared by power-up, register writes
// - Latch cleared when program or erase completes
// - Latch clearing holds in dual, quad too
// - No modify before power-up write delay
// - Ready flag is inverse of busy, but is also set while the engine is halted
`timescale 1ns/100ps
module ffsg_flag_guard #(
	parameter int unsigned PUW_CYC = ffsg_pkg::PUW_TIME_US * ffsg_pkg::CLK_MHZ
) (
	// System
	input  wire logic                  clk_sys,
	input  wire logic                  nrst,
	// Serial pins
	input  wire logic                  sclk,
	input  wire logic                  sel_n,
	input  wire logic [3:0]            dq,
	input  wire logic                  wp_n,
	input  wire logic                  vpp_high,
	// Configuration and engine
	input  wire ffsg_pkg::ffsg_proto_e proto,
	input  wire ffsg_pkg::ffsg_prot_s  prot,
	input  wire ffsg_pkg::ffsg_eng_s   eng,
	// Results
	output ffsg_pkg::ffsg_start_s      cmd,
	output logic [7:0]                 flag_status_reg,
	output logic                       write_latch
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [7:0]         sy1;
	logic [7:0]         sy2;
	logic               sclk_d;
	logic               sel_d;
	wire  [7:0]         pin_v = {sclk, sel_n, wp_n, vpp_high, dq};

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			sy1    <= 8'h40;
			sy2    <= 8'h40;
			sclk_d <= 1'b0;
			sel_d  <= 1'b0;
		end
		else
		begin
			sy1    <= pin_v;
			sy2    <= sy1;
			sclk_d <= sy2[7];
			sel_d  <= ~sy2[6];
		end
	end

	wire        sel       = ~sy2[6];
	wire        sel_rise  = sel & ~sel_d;
	wire        deselect  = ~sel & sel_d;
	wire        sclk_rise = sy2[7] & ~sclk_d;
	wire        wp_on     = ~sy2[5];
	wire        vpp_s     = sy2[4];
	wire  [3:0] dq_s      = sy2[3:0];

	// ----------------------------------------
	// Opcode shifter and clock count
	// ----------------------------------------
	logic [7:0]         opc;
	logic [7:0]         next_opc;
	logic [2:0]         bit_cnt;
	logic [3:0]         edge_cnt;
	logic [3:0]         need;

	always_comb
	begin
		case (proto)
			ffsg_pkg::P_DUAL:
			begin
				next_opc = {opc[5:0], dq_s[1:0]};
				need     = 4'h4;
			end
			ffsg_pkg::P_QUAD:
			begin
				next_opc = {opc[3:0], dq_s};
				need     = 4'h2;
			end
			default:
			begin
				next_opc = {opc[6:0], dq_s[0]};
				need     = 4'h8;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			opc      <= 8'h00;
			bit_cnt  <= 3'h0;
			edge_cnt <= 4'h0;
		end
		else if (sel_rise)
		begin
			opc      <= 8'h00;
			bit_cnt  <= 3'h0;
			edge_cnt <= 4'h0;
		end
		else if (sel && sclk_rise)
		begin
			bit_cnt <= bit_cnt + 3'h1;
			if (edge_cnt < need)
				opc <= next_opc;
			if (edge_cnt != 4'hF)
				edge_cnt <= edge_cnt + 4'h1;
		end
	end

	// Only whole bytes of clocks count as a finished instruction
	wire byte_ok  = (bit_cnt == 3'h0) && (edge_cnt != 4'h0);
	wire eval     = deselect && byte_ok && (edge_cnt >= need);

	// ----------------------------------------
	// Instruction decode
	// ----------------------------------------
	wire ext      = proto == ffsg_pkg::P_EXT;
	wire is_wr_enable  = opc == ffsg_pkg::OP_WRITE_ENABLE;
	wire is_wr_disable = opc == ffsg_pkg::OP_WRITE_DISABLE;
	wire is_wr_status  = opc == ffsg_pkg::OP_WRITE_STATUS;
	wire is_lock_wr    = opc == ffsg_pkg::OP_LOCK_WRITE;
	wire is_otp   = opc == ffsg_pkg::OP_OTP;
	wire is_susp  = opc == ffsg_pkg::OP_SUSP;
	wire is_resm  = opc == ffsg_pkg::OP_RESM;
	wire is_clr   = opc == ffsg_pkg::OP_CLRF;
	wire is_xfp   = (opc == ffsg_pkg::OP_DFP) || (opc == ffsg_pkg::OP_DEFP)
		|| (opc == ffsg_pkg::OP_QFP) || (opc == ffsg_pkg::OP_QEFP);
	// Extended program forms exist only on the single-line protocol
	wire is_prog  = (opc == ffsg_pkg::OP_PAGE_PROGRAM) || (ext && is_xfp);
	wire is_erase = (opc == ffsg_pkg::OP_SUBSECTOR_ERASE) || (opc == ffsg_pkg::OP_LWIPE)
		|| (opc == ffsg_pkg::OP_CWIPE);
	wire is_pgm   = is_prog || is_otp;
	wire is_mod   = is_pgm || is_erase || is_wr_status || is_lock_wr;

	// ----------------------------------------
	// Power-up write delay
	// ----------------------------------------
	logic [31:0]        puw_cnt;
	logic               puw_done;

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			puw_cnt  <= 32'h0000_0000;
			puw_done <= 1'b0;
		end
		else if (!puw_done)
		begin
			if (puw_cnt >= PUW_CYC - 1)
				puw_done <= 1'b1;
			else
				puw_cnt <= puw_cnt + 32'h0000_0001;
		end
	end

	// ----------------------------------------
	// Acceptance
	// ----------------------------------------
	ffsg_pkg::ffsg_op_e op;
	ffsg_pkg::ffsg_op_e next_op;
	logic               vpp_at_start;

	wire busy     = op != ffsg_pkg::ST_IDLE;
	wire f_eerr   = flag_status_reg[ffsg_pkg::FS_EERR];
	wire f_perr   = flag_status_reg[ffsg_pkg::FS_PERR];
	wire f_verr   = flag_status_reg[ffsg_pkg::FS_VERR];
	wire f_prot   = flag_status_reg[ffsg_pkg::FS_PROT];
	wire f_esus   = flag_status_reg[ffsg_pkg::FS_ESUS];
	wire f_psus   = flag_status_reg[ffsg_pkg::FS_PSUS];

	wire mod_go   = eval && is_mod && write_latch && puw_done && !busy;
	// A leftover error makes the new command look failed
	wire stale    = (is_pgm && (f_perr || f_prot || f_verr))
		|| (is_erase && (f_eerr || f_prot || f_verr))
		|| ((is_wr_status || is_lock_wr) && f_prot);
	wire prot_hit = ((is_prog || is_erase) && prot.sector_locked)
		|| (is_otp && prot.otp_locked)
		|| (is_wr_status && prot.status_write_disable_bit && wp_on);
	wire start    = mod_go && !stale && !prot_hit;
	wire refuse   = mod_go && !stale && prot_hit;
	wire susp     = eval && is_susp && busy;
	wire resm     = eval && is_resm;
	wire clr      = eval && is_clr;
	wire done     = busy && eng.done;
	wire pe_run   = (op == ffsg_pkg::ST_PROG) || (op == ffsg_pkg::ST_ERASE);

	always_comb
	begin
		next_op = op;
		case (op)
			ffsg_pkg::ST_IDLE:
				if (start)
					next_op = is_pgm ? ffsg_pkg::ST_PROG
						: is_erase ? ffsg_pkg::ST_ERASE : ffsg_pkg::ST_REG;
			ffsg_pkg::ST_PROG,
			ffsg_pkg::ST_ERASE,
			ffsg_pkg::ST_REG:
				if (eng.done)
					next_op = ffsg_pkg::ST_IDLE;
			default:
				next_op = ffsg_pkg::ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// Flag status register
	// ----------------------------------------
	logic [7:0]         next_flags;

	wire set_eerr = (refuse && is_erase)
		|| ((op == ffsg_pkg::ST_ERASE) && eng.fail);
	wire set_perr = (refuse && is_pgm)
		|| ((op == ffsg_pkg::ST_PROG) && eng.fail)
		|| ((op == ffsg_pkg::ST_PROG) && eng.one_on_zero
			&& vpp_at_start && eng.pattern_64);
	wire set_verr = pe_run && vpp_at_start && !vpp_s;

	always_comb
	begin
		next_flags = 8'h00;
		next_flags[ffsg_pkg::FS_RDY]  = (next_op == ffsg_pkg::ST_IDLE) || eng.halted;
		next_flags[ffsg_pkg::FS_ESUS] = (susp && (op == ffsg_pkg::ST_ERASE))
			|| (f_esus && !resm);
		next_flags[ffsg_pkg::FS_PSUS] = (susp && (op == ffsg_pkg::ST_PROG))
			|| (f_psus && !resm);
		// Set wins over a clear in the same cycle
		next_flags[ffsg_pkg::FS_EERR] = set_eerr || (f_eerr && !clr);
		next_flags[ffsg_pkg::FS_PERR] = set_perr || (f_perr && !clr);
		next_flags[ffsg_pkg::FS_VERR] = set_verr || (f_verr && !clr);
		next_flags[ffsg_pkg::FS_PROT] = refuse || (f_prot && !clr);
	end

	// ----------------------------------------
	// State, latch and start
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			op              <= ffsg_pkg::ST_IDLE;
			flag_status_reg <= ffsg_pkg::FLAG_RST;
			vpp_at_start    <= 1'b0;
			cmd             <= '0;
			write_latch     <= 1'b0;
		end
		else
		begin
			op              <= next_op;
			flag_status_reg <= next_flags;
			cmd.start       <= start;
			if (start)
			begin
				cmd.opcode   <= opc;
				vpp_at_start <= vpp_s;
			end
			if (eval && is_wr_enable)
				write_latch <= 1'b1;
			else if (done || refuse || (eval && is_wr_disable))
				write_latch <= 1'b0;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	AST_ESUS_SET: assert property (
		susp && (op == ffsg_pkg::ST_ERASE) |=> f_esus && $stable(f_psus))
		else $error("erase suspend flag not set");
	AST_PSUS_SET: assert property (
		susp && (op == ffsg_pkg::ST_PROG) |=> f_psus && $stable(f_esus))
		else $error("program suspend flag not set");
	AST_RESUME_CLR: assert property (
		resm |=> !f_esus && !f_psus)
		else $error("resume left a suspend flag set");
	AST_ERR_STICKY: assert property (
		f_eerr && !clr |=> f_eerr)
		else $error("erase error lost without clear");
	AST_START_NEEDS_LATCH: assert property (
		cmd.start |-> $past(write_latch) && $past(puw_done))
		else $error("modify started without latch or delay");
	AST_WHOLE_BYTES: assert property (
		cmd.start |-> $past(bit_cnt) == 3'h0)
		else $error("modify started on partial byte");
	AST_LATCH_CLR_DONE: assert property (
		done && !(eval && is_wr_enable) |=> !write_latch)
		else $error("latch survived completion");
	AST_WP_REFUSE: assert property (
		mod_go && !stale && is_wr_status && prot.status_write_disable_bit && wp_on
		|=> f_prot && !cmd.start)
		else $error("protected status write not refused");
	AST_DISCARD: assert property (
		eval && is_mod && !write_latch && !busy
		|=> $stable(flag_status_reg[5:1]) && !cmd.start)
		else $error("discarded modify changed state");
	AST_RDY_BUSY: assert property (
		busy && !eng.done && !eng.halted ##1 busy |-> !flag_status_reg[ffsg_pkg::FS_RDY])
		else $error("ready flag high while busy");
	AST_VPP_DROP: assert property (
		pe_run && vpp_at_start && !vpp_s |=> f_verr)
		else $error("supply drop not flagged");

endmodule // ffsg_flag_guard

// [verification/ffsg_host_model.sv]
// Host-side serial controller model that issues flash instructions
`timescale 1ns/100ps
module ffsg_host_model (
	// Serial pins
	output logic       sclk,
	output logic       sel_n,
	output logic [3:0] dq
);
	initial
	begin
		sclk = 1'b0;
		sel_n = 1'b1;
		dq = 4'h0;
	end

	// Opcode MSB first on w lines, zero padding after it
	task automatic frame(input logic [7:0] op, input int rises, input int w);
		logic [7:0] sh;
		sh = op;
		sel_n = 1'b0;
		for (int i = 0; i < rises; i++)
		begin
			dq = (w == 4) ? sh[7:4] : (w == 2) ? {2'b00, sh[7:6]} : {3'b000, sh[7]};
			sh = sh << w;
			#62.5 sclk = 1'b1;
			#62.5 sclk = 1'b0;
		end
		#62.5 sel_n = 1'b1;
		// Released lines must not keep a stale value
		dq = ~dq;
	endtask
endmodule // ffsg_host_model

// [verification/ffsg_flag_guard_tb.sv]
// Self-checking bench of the flag status and write guard
`timescale 1ns/100ps
module ffsg_flag_guard_tb;
	logic                  clk_sys = 1'b0;
	logic                  nrst = 1'b0;
	logic                  sclk;
	logic                  sel_n;
	logic [3:0]            dq;
	logic                  wp_n = 1'b1;
	logic                  vpp_high = 1'b0;
	ffsg_pkg::ffsg_proto_e proto = ffsg_pkg::P_EXT;
	ffsg_pkg::ffsg_prot_s  prot = '0;
	ffsg_pkg::ffsg_eng_s   eng = '0;
	ffsg_pkg::ffsg_start_s cmd;
	logic [7:0]            flag_status_reg;
	logic                  write_latch;
	logic [7:0]            n_start = 8'h00;
	logic [7:0]            en = 8'h00;
	int                    w = 1;
	int                    n_errors = 0;
	int                    num_checks = 0;
	int                    cyc = 0;
	logic [7:0]            ops [13] = '{ffsg_pkg::OP_PAGE_PROGRAM, ffsg_pkg::OP_DFP,
		ffsg_pkg::OP_DEFP, ffsg_pkg::OP_QFP, ffsg_pkg::OP_QEFP, ffsg_pkg::OP_SUBSECTOR_ERASE,
		ffsg_pkg::OP_LWIPE, ffsg_pkg::OP_CWIPE, ffsg_pkg::OP_OTP, ffsg_pkg::OP_WRITE_STATUS,
		ffsg_pkg::OP_LOCK_WRITE, ffsg_pkg::OP_PAGE_PROGRAM, ffsg_pkg::OP_CWIPE};

	always #5 clk_sys = ~clk_sys;

	ffsg_host_model host (.sclk(sclk), .sel_n(sel_n), .dq(dq));

	ffsg_flag_guard #(.PUW_CYC(300)) DUT (.clk_sys(clk_sys), .nrst(nrst), .sclk(sclk),
		.sel_n(sel_n), .dq(dq), .wp_n(wp_n), .vpp_high(vpp_high), .proto(proto),
		.prot(prot), .eng(eng), .cmd(cmd), .flag_status_reg(flag_status_reg),
		.write_latch(write_latch));

	always @(posedge clk_sys)
	begin
		if (cmd.start === 1'b1)
			n_start <= n_start + 8'h01;
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			report_and_stop();
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic report_and_stop();
		$display("errors %0d checks %0d", n_errors, num_checks);
		if (n_errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %s exp %h got %h", name, exp, got);
		end
	endtask

	task automatic st(input logic [7:0] f, input logic l, input logic [7:0] n);
		chk("flags", f, flag_status_reg);
		chk("latch", {7'h00, l}, {7'h00, write_latch});
		chk("starts", n, n_start);
	endtask

	task automatic send(input logic [7:0] op, input int rises);
		host.frame(op, rises, w);
		repeat (8) @(negedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] op);
		send(ffsg_pkg::OP_WRITE_ENABLE, 8);
		send(op, 8);
	endtask

	task automatic pulse(input logic [4:0] e);
		@(negedge clk_sys) eng = e;
		@(negedge clk_sys) eng = '0;
		repeat (3) @(negedge clk_sys);
	endtask

	task automatic run_op(input logic [7:0] op);
		wr(op);
		en++;
		st(8'h00, 1'b1, en);
		chk("opcode", op, cmd.opcode);
		pulse(5'b10000);
		st(8'h80, 1'b0, en);
	endtask

	task automatic prot_case(input logic [2:0] p, input logic [7:0] op, input logic [7:0] f);
		prot = p;
		wr(op);
		st(f, 1'b0, en);
		send(ffsg_pkg::OP_CLRF, 8);
		st(8'h80, 1'b0, en);
		prot = '0;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (6) @(negedge clk_sys);
		st(8'h80, 1'b0, 8'h00);
		nrst = 1'b1;
		// Synchronisers settle before the first frame
		repeat (3) @(negedge clk_sys);
		wr(ffsg_pkg::OP_PAGE_PROGRAM);
		st(8'h80, 1'b1, en);
		repeat (100) @(negedge clk_sys);
		send(ffsg_pkg::OP_WRITE_DISABLE, 8);
		st(8'h80, 1'b0, en);
		send(ffsg_pkg::OP_PAGE_PROGRAM, 8);
		st(8'h80, 1'b0, en);
		send(ffsg_pkg::OP_WRITE_ENABLE, 8);
		send(ffsg_pkg::OP_PAGE_PROGRAM, 7);
		st(8'h80, 1'b1, en);
		for (int i = 0; i < 13; i++)
		begin
			proto = (i == 11) ? ffsg_pkg::P_DUAL : (i == 12) ? ffsg_pkg::P_QUAD : ffsg_pkg::P_EXT;
			w = (i == 11) ? 2 : (i == 12) ? 4 : 1;
			run_op(ops[i]);
		end
		// Extended program forms are no program in quad mode
		send(ffsg_pkg::OP_WRITE_ENABLE, 8);
		send(ffsg_pkg::OP_QFP, 8);
		st(8'h80, 1'b1, en);
		proto = ffsg_pkg::P_EXT;
		w = 1;
		wr(ffsg_pkg::OP_PAGE_PROGRAM);
		en++;
		send(ffsg_pkg::OP_SUSP, 8);
		st(8'h04, 1'b1, en);
		send(ffsg_pkg::OP_RESM, 8);
		st(8'h00, 1'b1, en);
		pulse(5'b10000);
		wr(ffsg_pkg::OP_SUBSECTOR_ERASE);
		en++;
		send(ffsg_pkg::OP_SUSP, 8);
		st(8'h40, 1'b1, en);
		// Host trusts the suspend flag only once ready shows the halt
		@(negedge clk_sys) eng = 5'b00001;
		repeat (3) @(negedge clk_sys);
		st(8'hc0, 1'b1, en);
		eng = '0;
		send(ffsg_pkg::OP_RESM, 8);
		st(8'h00, 1'b1, en);
		pulse(5'b11000);
		st(8'ha0, 1'b0, en);
		wr(ffsg_pkg::OP_SUBSECTOR_ERASE);
		st(8'ha0, 1'b1, en);
		send(ffsg_pkg::OP_CLRF, 8);
		st(8'h80, 1'b1, en);
		wr(ffsg_pkg::OP_PAGE_PROGRAM);
		en++;
		pulse(5'b11000);
		st(8'h90, 1'b0, en);
		send(ffsg_pkg::OP_CLRF, 8);
		vpp_high = 1'b1;
		wr(ffsg_pkg::OP_PAGE_PROGRAM);
		en++;
		pulse(5'b00110);
		st(8'h10, 1'b1, en);
		vpp_high = 1'b0;
		repeat (8) @(negedge clk_sys);
		st(8'h18, 1'b1, en);
		pulse(5'b10000);
		send(ffsg_pkg::OP_CLRF, 8);
		st(8'h80, 1'b0, en);
		wr(ffsg_pkg::OP_PAGE_PROGRAM);
		en++;
		pulse(5'b10110);
		st(8'h80, 1'b0, en);
		prot_case(3'b100, ffsg_pkg::OP_PAGE_PROGRAM, 8'h92);
		prot_case(3'b100, ffsg_pkg::OP_SUBSECTOR_ERASE, 8'ha2);
		prot_case(3'b010, ffsg_pkg::OP_OTP, 8'h92);
		wp_n = 1'b0;
		prot_case(3'b001, ffsg_pkg::OP_WRITE_STATUS, 8'h82);
		wp_n = 1'b1;
		send(ffsg_pkg::OP_WRITE_ENABLE, 8);
		st(8'h80, 1'b1, en);
		// Power cycle in mid-run: latch drops and the write delay restarts
		nrst = 1'b0;
		@(negedge clk_sys) st(8'h80, 1'b0, en);
		nrst = 1'b1;
		repeat (3) @(negedge clk_sys);
		wr(ffsg_pkg::OP_PAGE_PROGRAM);
		st(8'h80, 1'b1, en);
		report_and_stop();
	end
endmodule // ffsg_flag_guard_tb
